// file: src/almmon_map.vh
// constants for the alarm monitor: bit positions, widths and reset values
`ifndef ALMMON_MAP_VH
`define ALMMON_MAP_VH
`define ALMMON_NUM_ALM 6
`define ALMMON_NUM_LANES 8
`define ALMMON_BIT_CPLL 0
`define ALMMON_BIT_SPLL 1
`define ALMMON_BIT_LINK 2
`define ALMMON_BIT_SYSREF 3
`define ALMMON_BIT_CLKUP 4
`define ALMMON_BIT_FIFO 5
`define ALMMON_STATUS_RST 6'h00
`define ALMMON_MASK_RST 6'h3f
`define ALMMON_LANE_RST 8'h00
`define ALMMON_PINSEL_ALARM 2'h1
`define ALMMON_PINSEL_RST 2'h0
`endif

// file: src/almmon_sync.v
// two-flop synchroniser bank for inputs from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module almmon_sync #(
  parameter W = 1
) (
  input wire clk,
  input wire reset_n,
  input wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] stage1;
  reg [W-1:0] stage2;
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stage1 <= {W{1'b0}};
      stage2 <= {W{1'b0}};
    end
    else
    begin
      stage1 <= d;
      stage2 <= stage1;
    end
  end
  assign q = stage2;
endmodule
`default_nettype wire

// file: src/almmon_top.v
// alarm monitor: sticky alarm status, mask, summary and status pin
`timescale 1ns/1ps
`default_nettype none
`include "almmon_map.vh"
module almmon_top (
  input wire CLK_SYS,
  input wire RESET_N,
  input wire CPLL_LOCKED,
  input wire SPLL_LOCKED,
  input wire LINK_IN_DATA_STATE,
  input wire SYSREF_REALIGN,
  input wire CHAN_A_CLK_PHASE,
  input wire CHAN_B_CLK_PHASE,
  input wire [`ALMMON_NUM_LANES-1:0] LANE_FIFO_UPSET,
  input wire LINK_ENABLE,
  input wire CHAN_A_POWERDOWN,
  input wire CHAN_B_POWERDOWN,
  input wire [`ALMMON_NUM_ALM-1:0] ALARM_CLEAR,
  input wire [`ALMMON_NUM_LANES-1:0] LANE_FIFO_CLEAR,
  input wire [`ALMMON_NUM_ALM-1:0] ALARM_TYPE_MASK,
  input wire [1:0] STATUS_PIN_SELECT,
  input wire OTHER_STATUS,
  output reg [`ALMMON_NUM_ALM-1:0] ALARM_STATUS_BITS,
  output reg [`ALMMON_NUM_LANES-1:0] LANE_FIFO_ERROR_FLAGS,
  output reg ALARM_SUMMARY,
  output reg CALIBRATION_STATUS_PIN,
  output reg LINK_RESET_N,
  output reg SERIALIZER_POWER_ON,
  output reg LINK_CLOCK_ENABLE,
  output reg FIFO_RESET
);
  localparam NS = 6 + `ALMMON_NUM_LANES;

  wire [NS-1:0] raw_in;
  wire [NS-1:0] sync_in;
  wire cpll_locked;
  wire spll_locked;
  wire link_data;
  wire sysref_hit;
  wire phase_a;
  wire phase_b;
  wire [`ALMMON_NUM_LANES-1:0] lane_upset;
  reg [`ALMMON_NUM_ALM-1:0] event_now;
  reg [`ALMMON_NUM_ALM-1:0] next_status;
  reg [`ALMMON_NUM_LANES-1:0] next_lane;
  reg [`ALMMON_NUM_ALM-1:0] unmasked;
  wire link_en_s;
  wire [2:0] misc_sync;
  wire chan_pair_up;

  assign raw_in = {LANE_FIFO_UPSET, CHAN_B_CLK_PHASE, CHAN_A_CLK_PHASE,
                   SYSREF_REALIGN, LINK_IN_DATA_STATE, SPLL_LOCKED,
                   CPLL_LOCKED};

  // every alarm source crosses from analog or link logic: synchronise first
  almmon_sync #(
    .W(NS)
  ) u_sync_src (
    .clk(CLK_SYS),
    .reset_n(RESET_N),
    .d(raw_in),
    .q(sync_in)
  );

  almmon_sync #(
    .W(3)
  ) u_sync_misc (
    .clk(CLK_SYS),
    .reset_n(RESET_N),
    .d({LINK_ENABLE, CHAN_B_POWERDOWN, CHAN_A_POWERDOWN}),
    .q(misc_sync)
  );
  assign link_en_s = misc_sync[2];
  // a powered-down channel has no clocks to compare, so no upset is judged
  assign chan_pair_up = ~misc_sync[0] & ~misc_sync[1];

  assign cpll_locked = sync_in[0];
  assign spll_locked = sync_in[1];
  assign link_data = sync_in[2];
  assign sysref_hit = sync_in[3];
  assign phase_a = sync_in[4];
  assign phase_b = sync_in[5];
  assign lane_upset = sync_in[NS-1:6];

  function any_set;
    input [`ALMMON_NUM_LANES-1:0] v;
    begin
      any_set = |v;
    end
  endfunction

  function keep_flag;
    input flag;
    input clear;
    begin
      keep_flag = flag & ~clear;
    end
  endfunction

  always @*
  begin
    event_now = {`ALMMON_NUM_ALM{1'b0}};
    event_now[`ALMMON_BIT_CPLL] = ~cpll_locked;
    event_now[`ALMMON_BIT_SPLL] = ~spll_locked;
    // link counts as out of data state also while held disabled
    event_now[`ALMMON_BIT_LINK] = ~link_data | ~link_en_s;
    event_now[`ALMMON_BIT_SYSREF] = sysref_hit;
    // one sample per CLK_SYS tick; any mismatch with link enabled and both channels up is an upset
    event_now[`ALMMON_BIT_CLKUP] = link_en_s & chan_pair_up &
                                   (phase_a ^ phase_b);
    event_now[`ALMMON_BIT_FIFO] = any_set(next_lane);
  end

  // per-lane flags; set wins over clear, link disable blocks new sets but keeps flags
  genvar g;
  generate
    for (g = 0; g < `ALMMON_NUM_LANES; g = g + 1)
    begin : g_lane
      always @*
      begin
        if (!link_en_s)
          next_lane[g] = keep_flag(LANE_FIFO_ERROR_FLAGS[g],
                                   LANE_FIFO_CLEAR[g]);
        else if (lane_upset[g])
          next_lane[g] = 1'b1;
        else
          next_lane[g] = keep_flag(LANE_FIFO_ERROR_FLAGS[g],
                                   LANE_FIFO_CLEAR[g]);
      end
    end
  endgenerate

  always @*
  begin
    // set wins over a write-1 clear in the same cycle
    next_status = (ALARM_STATUS_BITS & ~ALARM_CLEAR) | event_now;
    unmasked = next_status & ~ALARM_TYPE_MASK;
  end

  always @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      ALARM_STATUS_BITS <= `ALMMON_STATUS_RST;
      LANE_FIFO_ERROR_FLAGS <= `ALMMON_LANE_RST;
    end
    else
    begin
      ALARM_STATUS_BITS <= next_status;
      LANE_FIFO_ERROR_FLAGS <= next_lane;
    end
  end

  // summary, and the pin when STATUS_PIN_SELECT picks the alarm, are built from the value being stored, so they never lag
  always @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      ALARM_SUMMARY <= 1'b0;
      CALIBRATION_STATUS_PIN <= 1'b0;
    end
    else
    begin
      ALARM_SUMMARY <= |unmasked;
      if (STATUS_PIN_SELECT == `ALMMON_PINSEL_ALARM)
        CALIBRATION_STATUS_PIN <= |unmasked;
      else
        CALIBRATION_STATUS_PIN <= OTHER_STATUS;
    end
  end

  always @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      LINK_RESET_N <= 1'b0;
    end
    else
    begin
      LINK_RESET_N <= link_en_s;
    end
  end

  always @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      SERIALIZER_POWER_ON <= 1'b0;
      LINK_CLOCK_ENABLE <= 1'b0;
    end
    else
    begin
      SERIALIZER_POWER_ON <= link_en_s;
      LINK_CLOCK_ENABLE <= link_en_s;
    end
  end

  always @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      FIFO_RESET <= 1'b1;
    end
    else
    begin
      // fifo held in reset while disabled, released on re-enable
      FIFO_RESET <= ~link_en_s;
    end
  end
endmodule
`default_nettype wire

// file: verif/almmon_asserts.sv
// checker on the alarm monitor ports
`timescale 1ns/1ps
`default_nettype none
module almmon_asserts (input wire CLK_SYS, RESET_N, LINK_ENABLE, OTHER_STATUS,
  ALARM_SUMMARY, CALIBRATION_STATUS_PIN, LINK_RESET_N, FIFO_RESET,
  input wire [5:0] ALARM_CLEAR, ALARM_TYPE_MASK, ALARM_STATUS_BITS,
  input wire [7:0] LANE_FIFO_CLEAR, LANE_FIFO_ERROR_FLAGS,
  input wire [1:0] STATUS_PIN_SELECT);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);
  AST_SUM: assert property (ALARM_SUMMARY ==
    |(ALARM_STATUS_BITS & ~$past(ALARM_TYPE_MASK))) else $error("sum");
  AST_PIN: assert property ($past(STATUS_PIN_SELECT) == 2'h1 |->
    CALIBRATION_STATUS_PIN == ALARM_SUMMARY) else $error("pin");
  AST_PIN_OTHER: assert property ($past(STATUS_PIN_SELECT) != 2'h1 |->
    CALIBRATION_STATUS_PIN == $past(OTHER_STATUS)) else $error("other");
  AST_STICKY: assert property ((6'h1f & ~ALARM_STATUS_BITS &
    $past(ALARM_STATUS_BITS) & ~$past(ALARM_CLEAR)) == 0) else $error("st");
  AST_LANE: assert property ((~LANE_FIFO_ERROR_FLAGS &
    $past(LANE_FIFO_ERROR_FLAGS) & ~$past(LANE_FIFO_CLEAR)) == 0)
    else $error("ln");
  AST_FIFO: assert property (ALARM_STATUS_BITS[5] ==
    |LANE_FIFO_ERROR_FLAGS) else $error("fifo");
  AST_LINK: assert property (FIFO_RESET != LINK_RESET_N)
    else $error("link");
  AST_ON: assert property ($rose(LINK_ENABLE) |-> ##[2:4] LINK_RESET_N)
    else $error("on");
  AST_OFF: assert property (!LINK_ENABLE [*4] |-> FIFO_RESET)
    else $error("off");
  cover property (ALARM_STATUS_BITS[4]);
  cover property (ALARM_SUMMARY && CALIBRATION_STATUS_PIN);
  cover property ($fell(FIFO_RESET));
endmodule
bind almmon_top almmon_asserts i_almmon_asserts (.*);
`default_nettype wire

// file: verif/almmon_host.sv
// host model: one-cycle write-one-to-clear pulses
`timescale 1ns/1ps
`default_nettype none
module almmon_host (input wire clk, go, input wire [13:0] bits,
  output logic [5:0] clr = 0, output logic [7:0] lane_clr = 0);
  // launched just after the edge, so the design never sees a half pulse
  always @(posedge clk)
    {lane_clr, clr} <= go ? bits : 14'h0000;
endmodule
`default_nettype wire

// file: verif/test_alarm_monitor.sv
// bench: host model clears alarms, a watcher checks every status change once armed
`timescale 1ns/1ps
`default_nettype none
module test_alarm_monitor;
  logic c = 0, rn = 0, en = 1, go = 0, o = 0, on = 0, s, p;
  logic [5:0] a = 0, m = 0, cl, st, q[$];
  logic [7:0] ln = 0, lc, lf;
  logic [13:0] b = 0;
  logic [1:0] sel = 0;
  int seed = 40451, err_count = 0, checks_done = 0;
  always #10 c = ~c;
  almmon_host i_almmon_host (.clk(c), .go(go), .bits(b), .clr(cl),
    .lane_clr(lc));
  almmon_top i_almmon_top (.CLK_SYS(c), .RESET_N(rn), .CPLL_LOCKED(~a[0]),
    .SPLL_LOCKED(~a[1]), .LINK_IN_DATA_STATE(~a[2]), .SYSREF_REALIGN(a[3]),
    .CHAN_A_CLK_PHASE(1'b0), .CHAN_B_CLK_PHASE(a[4]),
    .LANE_FIFO_UPSET(a[5] ? ln : 8'h00), .LINK_ENABLE(en),
    .CHAN_A_POWERDOWN(1'b0), .CHAN_B_POWERDOWN(1'b0), .ALARM_CLEAR(cl),
    .LANE_FIFO_CLEAR(lc), .ALARM_TYPE_MASK(m), .STATUS_PIN_SELECT(sel),
    .OTHER_STATUS(o), .ALARM_STATUS_BITS(st), .LANE_FIFO_ERROR_FLAGS(lf),
    .ALARM_SUMMARY(s), .CALIBRATION_STATUS_PIN(p), .LINK_RESET_N(),
    .SERIALIZER_POWER_ON(), .LINK_CLOCK_ENABLE(), .FIFO_RESET());
  task chk(string n, logic [7:0] v, e);
    checks_done++;
    if (v !== e) err_count++;
    if (v !== e) $display("unexpected %s expected %h seen %h", n, e, v);
  endtask
  task conclude;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // a clear is only noted once the watcher is armed
  task clear(logic [5:0] x);
    if (on) q.push_back(6'h00);
    b = {8'hff, x};
    go = 1;
    @(negedge c) go = 0;
    repeat (4) @(negedge c);
  endtask
  always @(st)
    if (on) chk("status", st, q.pop_front());
  initial
  begin
    repeat (3) @(negedge c);
    rn = 1;
    repeat (6) @(negedge c);
    clear(6'h3f);
    on = 1;
    for (int k = 0; k < 12; k++)
    begin
      {o, m} = 7'($random(seed));
      sel = {1'b0, k[0]};
      ln = 8'h01 << k[2:0];
      @(negedge c) q.push_back(6'h01 << (k % 6));
      a = 6'h01 << (k % 6);
      repeat (2) @(negedge c);
      a = 0;
      repeat (6) @(negedge c);
      chk("lanes", lf, k % 6 == 5 ? ln : 8'h00);
      chk("summary", s, |((6'h01 << (k % 6)) & ~m));
      chk("pin", p, sel == 2'h1 ? |((6'h01 << (k % 6)) & ~m) : o);
      clear(6'h01 << (k % 6));
    end
    q.push_back(6'h04);
    en = 0;
    repeat (6) @(negedge c);
    en = 1;
    repeat (6) @(negedge c);
    clear(6'h04);
    chk("queue", q.size(), 0);
    conclude;
  end
endmodule
`default_nettype wire
